// file: rtl/aomb_pkg.sv
package aomb_pkg;
    localparam int unsigned AMP_MAX = 32'h7fffffff;
    localparam int unsigned AMP_MIN = 32'h00000001;
    localparam logic [15:0] PHASE_MAX = 16'h0e0f;     // 3599 tenths of a degree
    localparam logic [15:0] PHASE_FULL = 16'h0e10;    // 3600 tenths
    localparam logic [12:0] FREQ_MIN = 13'h0001;
    localparam logic [12:0] FREQ_MAX = 13'h1388;      // 5000 cycles per minute
    localparam logic [15:0] ERR_AMP = 16'h0019;       // 25
    localparam logic [15:0] ERR_PHASE = 16'h001a;     // 26
    localparam logic [15:0] ERR_FREQ = 16'h001b;      // 27
    localparam logic [15:0] ERR_SPEED = 16'h0136;     // 310
    localparam logic [15:0] CODE_MAX = 16'h7fff;
    localparam int CLK_HZ = 50000000;
    localparam int SEC_PER_MIN = 60;
    // Phase accumulator: 32-bit fraction of a revolution
    localparam int PHASE_ACC_W = 32;
    localparam int SINE_W = 16;
    localparam int SINE_STEPS = 64;                   // Table steps per quarter wave; the table holds 65 points
    typedef enum logic [1:0] {AOMB_IDLE, AOMB_RUN} aomb_osc_e;
endpackage : aomb_pkg

// file: rtl/aomb_axis.sv
`timescale 1ns/1ps
`default_nettype none
module aomb_axis #(
    parameter int AXES = 4,
    parameter int AXIS_IDX = 0
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Oscillation command
    input wire logic osc_start_i,
    input wire logic [31:0] osc_amp_i,
    input wire logic [15:0] osc_phase_i,
    input wire logic [12:0] osc_freq_i,
    input wire logic stop_i,
    input wire logic speed_change_i,
    output logic osc_busy_o,
    output logic signed [31:0] osc_pos_o,
    output logic [15:0] setting_err_o,
    output logic setting_err_pulse_o,
    output logic [15:0] minor_err_o,
    output logic minor_err_pulse_o,
    // Auxiliary code
    input wire logic prog_code_we_i,
    input wire logic [AXES-1:0] prog_code_axes_i,
    input wire logic [14:0] prog_code_i,
    input wire logic host_code_clr_i,
    input wire logic start_done_i,
    input wire logic pos_done_i,
    output logic start_complete_flag_o,
    output logic positioning_complete_flag_o,
    output logic [14:0] aux_code_o,
    // Backlash compensation
    input wire logic [15:0] backlash_pls_i,
    input wire logic home_dir_i,
    input wire logic move_i,
    input wire logic move_dir_i,
    output logic comp_pulse_o,
    output logic comp_dir_o,
    output logic comp_busy_o,
    output logic signed [31:0] feed_value_o
);
    // ************************************************************
    // Oscillation parameter check and run state
    // ************************************************************
    aomb_pkg::aomb_osc_e osc_st_r;
    logic [31:0] phase_r;
    logic [31:0] step_r;
    logic [31:0] amp_r;
    logic amp_bad;
    logic phase_bad;
    logic freq_bad;
    logic [31:0] step_nxt;
    logic [31:0] start_phase;

    assign amp_bad = (osc_amp_i < aomb_pkg::AMP_MIN) || (osc_amp_i > aomb_pkg::AMP_MAX);
    assign phase_bad = osc_phase_i > aomb_pkg::PHASE_MAX;
    assign freq_bad = (osc_freq_i < aomb_pkg::FREQ_MIN) || (osc_freq_i > aomb_pkg::FREQ_MAX);
    // Step per cycle = freq * 2^32 / (60 * clk); computed once at start to avoid a divider per cycle
    // Widen before the product: sixty times the clock overflows a 32-bit int
    assign step_nxt = 32'((64'(osc_freq_i) << aomb_pkg::PHASE_ACC_W)
        / (64'(aomb_pkg::SEC_PER_MIN) * 64'(aomb_pkg::CLK_HZ)));
    assign start_phase = 32'((64'(osc_phase_i) << aomb_pkg::PHASE_ACC_W)
        / 64'(aomb_pkg::PHASE_FULL));

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            osc_st_r <= aomb_pkg::AOMB_IDLE;
            phase_r <= 32'h00000000;
            step_r <= 32'h00000000;
            amp_r <= 32'h00000000;
            setting_err_o <= 16'h0000;
            setting_err_pulse_o <= 1'b0;
        end
        else
        begin
            setting_err_pulse_o <= 1'b0;
            case (osc_st_r)
                aomb_pkg::AOMB_IDLE:
                begin
                    if (osc_start_i)
                    begin
                        if (amp_bad)
                        begin
                            setting_err_o <= aomb_pkg::ERR_AMP;
                            setting_err_pulse_o <= 1'b1;
                        end
                        else if (phase_bad)
                        begin
                            setting_err_o <= aomb_pkg::ERR_PHASE;
                            setting_err_pulse_o <= 1'b1;
                        end
                        else if (freq_bad)
                        begin
                            setting_err_o <= aomb_pkg::ERR_FREQ;
                            setting_err_pulse_o <= 1'b1;
                        end
                        else if (!stop_i)
                        begin
                            osc_st_r <= aomb_pkg::AOMB_RUN;
                            phase_r <= start_phase;
                            step_r <= step_nxt;
                            amp_r <= osc_amp_i;
                        end
                    end
                end
                aomb_pkg::AOMB_RUN:
                begin
                    if (stop_i)
                        osc_st_r <= aomb_pkg::AOMB_IDLE;
                    else
                        phase_r <= phase_r + step_r;
                end
                default: osc_st_r <= aomb_pkg::AOMB_IDLE;
            endcase
        end
    end

    assign osc_busy_o = (osc_st_r == aomb_pkg::AOMB_RUN);

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            minor_err_o <= 16'h0000;
            minor_err_pulse_o <= 1'b0;
        end
        else
        begin
            minor_err_pulse_o <= 1'b0;
            if (osc_busy_o && speed_change_i)
            begin
                minor_err_o <= aomb_pkg::ERR_SPEED;
                minor_err_pulse_o <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Sine lookup: quarter wave table, folded by quadrant
    // ************************************************************
    function automatic logic [15:0] sine_q(input logic [5:0] idx);
        real r;
        begin
            r = $sin(3.14159265358979 * idx / (2.0 * aomb_pkg::SINE_STEPS));
            sine_q = 16'($rtoi(r * 32767.0));
        end
    endfunction

    logic [15:0] sine_tab [aomb_pkg::SINE_STEPS+1];
    generate
        for (genvar g = 0; g <= aomb_pkg::SINE_STEPS; g++)
        begin : g_tab
            if (g == aomb_pkg::SINE_STEPS)
                assign sine_tab[g] = 16'h7fff;
            else
                assign sine_tab[g] = sine_q(6'(g));
        end
    endgenerate

    logic [1:0] quad;
    logic [5:0] qidx;
    logic [6:0] tidx;
    logic [15:0] mag;
    logic signed [47:0] prod;
    assign quad = phase_r[31:30];
    assign qidx = phase_r[29:24];
    assign tidx = quad[0] ? 7'(aomb_pkg::SINE_STEPS) - {1'b0, qidx} : {1'b0, qidx};
    assign mag = sine_tab[tidx];
    // Operands widened first so the product keeps all of its 46 bits
    assign prod = ($signed(48'(amp_r)) * $signed(48'(mag))) >>> 15;

    // No ramp: position jumps straight onto the curve from the first cycle
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            osc_pos_o <= 32'sh00000000;
        else if (osc_busy_o)
            osc_pos_o <= quad[1] ? -32'(prod) : 32'(prod);
    end

    // ************************************************************
    // Auxiliary code store and completion flags
    // ************************************************************
    logic prog_hit;
    assign prog_hit = prog_code_we_i && prog_code_axes_i[AXIS_IDX];

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            aux_code_o <= 15'h0000;
        else if (prog_hit)
            aux_code_o <= prog_code_i;
        else if (host_code_clr_i)
            aux_code_o <= 15'h0000;
    end

    // Flags rise one cycle after start_done_i or pos_done_i, with no tie to the code store
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            start_complete_flag_o <= 1'b0;
            positioning_complete_flag_o <= 1'b0;
        end
        else
        begin
            if (pos_done_i)
                positioning_complete_flag_o <= 1'b1;
            else if (osc_start_i || (move_i && !comp_busy_o && !start_complete_flag_o))
                positioning_complete_flag_o <= 1'b0;
            if (start_done_i)
                start_complete_flag_o <= 1'b1;
            else if (pos_done_i)
                start_complete_flag_o <= 1'b0;
        end
    end

    // ************************************************************
    // Backlash compensation
    // ************************************************************
    logic last_dir_r;
    logic moved_r;
    logic [15:0] comp_cnt_r;
    logic reversal;
    assign reversal = move_i && (moved_r ? (move_dir_i != last_dir_r)
        : (move_dir_i != home_dir_i));

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            last_dir_r <= 1'b0;
            moved_r <= 1'b0;
        end
        else if (move_i)
        begin
            last_dir_r <= move_dir_i;
            moved_r <= 1'b1;
        end
    end

    // 16-bit counter bounds the amount to 65535 pulses
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            comp_cnt_r <= 16'h0000;
        else if (reversal && comp_cnt_r == 16'h0000)
            comp_cnt_r <= backlash_pls_i;
        else if (comp_cnt_r != 16'h0000)
            comp_cnt_r <= comp_cnt_r - 16'h0001;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            comp_pulse_o <= 1'b0;
            comp_dir_o <= 1'b0;
            feed_value_o <= 32'sh00000000;
        end
        else
        begin
            comp_pulse_o <= comp_cnt_r != 16'h0000;
            if (reversal)
                comp_dir_o <= move_dir_i;
            if (comp_cnt_r != 16'h0000)
                feed_value_o <= comp_dir_o ? feed_value_o - 32'sh00000001
                    : feed_value_o + 32'sh00000001;
        end
    end

    assign comp_busy_o = comp_cnt_r != 16'h0000;
endmodule // aomb_axis
`default_nettype wire

// file: bench/aomb_servo_model.sv
`timescale 1ns/1ps
`default_nettype none
module aomb_servo_model (
    input wire logic mclk_i,
    input wire logic comp_pulse_i,
    input wire logic clr_i,
    output var int pulses_o
);
    // The motor only sees the extra feed; tally each burst from a clear
    always @(posedge mclk_i)
    begin
        if (clr_i)
            pulses_o <= 0;
        else if (comp_pulse_i)
            pulses_o <= pulses_o + 1;
    end
endmodule // aomb_servo_model
`default_nettype wire

// file: bench/aomb_axis_sva.sv
`timescale 1ns/1ps
`default_nettype none
module aomb_axis_sva #(
    parameter int AXES = 4,
    parameter int AXIS_IDX = 0
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic osc_start_i,
    input wire logic [31:0] osc_amp_i,
    input wire logic [15:0] osc_phase_i,
    input wire logic [12:0] osc_freq_i,
    input wire logic stop_i,
    input wire logic speed_change_i,
    input wire logic osc_busy_o,
    input wire logic [15:0] setting_err_o,
    input wire logic setting_err_pulse_o,
    input wire logic [15:0] minor_err_o,
    input wire logic minor_err_pulse_o,
    input wire logic prog_code_we_i,
    input wire logic [AXES-1:0] prog_code_axes_i,
    input wire logic [14:0] prog_code_i,
    input wire logic host_code_clr_i,
    input wire logic [14:0] aux_code_o
);
    wire logic go = osc_start_i && !osc_busy_o && !stop_i;
    wire logic a_ok = osc_amp_i != 32'h0 && !osc_amp_i[31];
    wire logic p_ok = osc_phase_i <= aomb_pkg::PHASE_MAX;
    wire logic f_ok = osc_freq_i != 13'h0 && osc_freq_i <= aomb_pkg::FREQ_MAX;
    wire logic own = prog_code_we_i && prog_code_axes_i[AXIS_IDX];
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_amp_error: assert property (go && !a_ok |=> setting_err_pulse_o
        && setting_err_o == aomb_pkg::ERR_AMP && !osc_busy_o) else $error("amp err");
    a_phase_error: assert property (go && a_ok && !p_ok |=> setting_err_pulse_o
        && setting_err_o == aomb_pkg::ERR_PHASE && !osc_busy_o) else $error("phase err");
    a_freq_error: assert property (go && a_ok && p_ok && !f_ok |=>
        setting_err_pulse_o && setting_err_o == aomb_pkg::ERR_FREQ) else $error("freq err");
    a_start_ok: assert property (go && a_ok && p_ok && f_ok |=>
        osc_busy_o && !setting_err_pulse_o) else $error("start lost");
    a_run_holds: assert property (osc_busy_o && !stop_i |=> osc_busy_o)
        else $error("run dropped");
    a_speed_reject: assert property (speed_change_i && osc_busy_o |=>
        minor_err_pulse_o && minor_err_o == aomb_pkg::ERR_SPEED && osc_busy_o)
        else $error("speed err");
    a_code_store: assert property (own |=> aux_code_o == $past(prog_code_i))
        else $error("code store");
    a_code_clear: assert property (host_code_clr_i && !own |=> aux_code_o == 15'h0)
        else $error("code clear");
endmodule // aomb_axis_sva
bind aomb_axis aomb_axis_sva #(.AXES(AXES), .AXIS_IDX(AXIS_IDX)) u_sva (.*);
`default_nettype wire

// file: bench/aomb_axis_tb.sv
`timescale 1ns/1ps
`default_nettype none
module aomb_axis_tb;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic osc_start_i = 1'b0, stop_i = 1'b0, speed_change_i = 1'b0;
    logic prog_code_we_i = 1'b0, host_code_clr_i = 1'b0, start_done_i = 1'b0;
    logic pos_done_i = 1'b0, home_dir_i = 1'b0, move_i = 1'b0, move_dir_i = 1'b0;
    logic [31:0] osc_amp_i = 32'h1;
    logic [15:0] osc_phase_i = 16'h0;
    logic [12:0] osc_freq_i = 13'h1;
    logic [3:0] prog_code_axes_i = 4'h0;
    logic [14:0] prog_code_i = 15'h0;
    logic [15:0] backlash_pls_i = 16'h0;
    logic osc_busy_o, setting_err_pulse_o, minor_err_pulse_o, start_complete_flag_o;
    logic positioning_complete_flag_o, comp_pulse_o, comp_dir_o, comp_busy_o;
    logic signed [31:0] osc_pos_o, feed_value_o;
    logic [15:0] setting_err_o, minor_err_o, e;
    logic [14:0] aux_code_o, c;
    logic clr = 1'b0;
    int mismatches = 0, n_compared = 0, cyc = 0, pulses, b;
    logic [31:0] ta [6] = '{32'h0, 32'h80000000, 32'h0, 32'h5, 32'h5, 32'h5};
    logic [15:0] tp [6] = '{16'h0, 16'h0, 16'h0e10, 16'h0e10, 16'h0384, 16'h0384};
    logic [12:0] tf [6] = '{13'h1, 13'h1, 13'h1, 13'h1, 13'h0, 13'h1389};
    aomb_axis #(.AXES(4), .AXIS_IDX(0)) dut (.*);
    aomb_servo_model u_servo (.mclk_i(mclk_i), .comp_pulse_i(comp_pulse_o),
        .clr_i(clr), .pulses_o(pulses));
    initial
    begin
        forever #10 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            results();
        end
    end
    // ****************
    // Shared tasks
    // ****************
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #2;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Priority of the codes follows the order of the parameter checks
    function automatic logic [15:0] err_of(logic [31:0] a, logic [15:0] p, logic [12:0] f);
        if (a == 32'h0 || a > aomb_pkg::AMP_MAX)
            return aomb_pkg::ERR_AMP;
        if (p > aomb_pkg::PHASE_MAX)
            return aomb_pkg::ERR_PHASE;
        if (f < aomb_pkg::FREQ_MIN || f > aomb_pkg::FREQ_MAX)
            return aomb_pkg::ERR_FREQ;
        return 16'h0;
    endfunction
    // The table is coarse, so the trajectory is held to a band around the ideal sine
    function automatic bit on_curve(logic signed [31:0] p, logic [31:0] a, logic [15:0] ph);
        real d;
        d = real'(p) - real'(a) * $sin(3.14159265358979 * real'(ph) / 1800.0);
        if (d < 0.0)
            d = -d;
        return d <= real'(a) / 32.0 + 2.0;
    endfunction
    task automatic prog(input logic we, input logic [3:0] m, input logic [14:0] v, input logic h);
        prog_code_we_i = we;
        prog_code_axes_i = m;
        prog_code_i = v;
        host_code_clr_i = h;
        step(1);
        prog_code_we_i = 1'b0;
        host_code_clr_i = 1'b0;
        step(1);
    endtask
    task automatic mv(input logic d, input int n);
        logic signed [31:0] f0;
        clr = 1'b1;
        move_dir_i = d;
        move_i = 1'b1;
        step(1);
        move_i = 1'b0;
        clr = 1'b0;
        f0 = feed_value_o;
        chk(comp_busy_o, n != 0);
        step(n + 8);
        chk(pulses, n);
        chk((feed_value_o > f0) ? feed_value_o - f0 : f0 - feed_value_o, n);
        chk(comp_busy_o, 1'b0);
        if (n != 0)
            chk(comp_dir_o, d);
    endtask
    initial
    begin
        void'($urandom(51266));
        step(8);
        rst_n_i = 1'b1;
        step(1);
        for (int i = 0; i < 15; i++)
        begin
            osc_amp_i = (i < 6) ? ta[i] : 32'h1 + $urandom() % aomb_pkg::AMP_MAX;
            osc_phase_i = (i < 6) ? tp[i] : 16'($urandom() % 3700);
            osc_freq_i = (i < 6) ? tf[i] : 13'($urandom() % 5100);
            if (i == 6)
                {osc_amp_i, osc_phase_i, osc_freq_i} = {aomb_pkg::AMP_MAX, 16'h0e0f, 13'h1388};
            // Starting at a velocity zero point keeps the first step small
            if (i == 7)
                {osc_amp_i, osc_phase_i, osc_freq_i} = {32'h00100000, 16'h0a8c, 13'h0001};
            e = err_of(osc_amp_i, osc_phase_i, osc_freq_i);
            osc_start_i = 1'b1;
            step(1);
            osc_start_i = 1'b0;
            chk(setting_err_pulse_o, e != 16'h0);
            chk(osc_busy_o, e == 16'h0);
            if (e != 16'h0)
                chk(setting_err_o, e);
            else
            begin
                step(20);
                chk(osc_busy_o, 1'b1);
                chk(on_curve(osc_pos_o, osc_amp_i, osc_phase_i), 1'b1);
                speed_change_i = 1'b1;
                step(1);
                speed_change_i = 1'b0;
                chk({minor_err_pulse_o, minor_err_o}, {1'b1, aomb_pkg::ERR_SPEED});
                chk(osc_busy_o, 1'b1);
                stop_i = 1'b1;
                step(1);
                stop_i = 1'b0;
                step(1);
                chk(osc_busy_o, 1'b0);
                speed_change_i = 1'b1;
                step(1);
                speed_change_i = 1'b0;
                chk(minor_err_pulse_o, 1'b0);
            end
            // Let an edge pass so the next start is a fresh pulse
            step(1);
            $display("osc case %0d done", i);
        end
        c = 15'($urandom());
        prog(1'b1, 4'h1 | 4'($urandom()), c, 1'b0);
        chk(aux_code_o, c);
        prog(1'b1, 4'he, ~c, 1'b0);
        chk(aux_code_o, c);
        prog(1'b0, 4'h0, c, 1'b1);
        chk(aux_code_o, 15'h0);
        prog(1'b1, 4'hf, aomb_pkg::CODE_MAX[14:0], 1'b1);
        chk(aux_code_o, aomb_pkg::CODE_MAX[14:0]);
        start_done_i = 1'b1;
        step(1);
        start_done_i = 1'b0;
        chk(start_complete_flag_o, 1'b1);
        pos_done_i = 1'b1;
        step(1);
        pos_done_i = 1'b0;
        chk(start_complete_flag_o, 1'b0);
        step(1);
        chk(positioning_complete_flag_o, 1'b1);
        $display("code test done");
        b = 3 + $urandom() % 6;
        backlash_pls_i = 16'(b);
        step(2);
        mv(1'b0, 0);
        chk(positioning_complete_flag_o, 1'b0);
        mv(1'b1, b);
        mv(1'b1, 0);
        mv(1'b0, b);
        rst_n_i = 1'b0;
        step(2);
        rst_n_i = 1'b1;
        step(1);
        mv(1'b1, b);
        // Home return direction flipped: the same first move now needs no compensation
        home_dir_i = 1'b1;
        rst_n_i = 1'b0;
        step(2);
        rst_n_i = 1'b1;
        step(1);
        mv(1'b1, 0);
        mv(1'b0, b);
        $display("backlash test done");
        results();
    end
endmodule // aomb_axis_tb
`default_nettype wire
